// >>> bench/fpe_core_model.sv
// Model of the integer core that offers floating-point instructions to the unit.
`timescale 1ns/1ps
module fpe_core_model (
  input logic aclk,
  input logic aresetn,
  input logic go,
  input fpe_pkg::fpe_instr_t go_instr,
  output logic instr_valid,
  output fpe_pkg::fpe_instr_t instr,
  input logic instr_ready,
  output logic busy
);
  assign busy = instr_valid;
  // The model never offers an extended save; a handler that uses one gives it 512 bytes on a 16-byte boundary.
  // The offer stays put until taken, so a stalled instruction keeps the operands a handler may read.
  // Once released, the payload is inverted so that nothing downstream can lean on a stale value.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr_valid <= 1'b0;
      instr <= '0;
    end
    else if (go)
    begin
      instr_valid <= 1'b1;
      instr <= go_instr;
    end
    else if (instr_valid && instr_ready)
    begin
      instr_valid <= 1'b0;
      instr <= fpe_pkg::fpe_instr_t'(~instr);
    end
  end
endmodule

// >>> bench/tb_fp_pending_exception_logic.sv
// Self-checking bench for the pending-exception unit.
`timescale 1ns/1ps
`include "fpe_regs.svh"
module tb_fp_pending_exception_logic;
  localparam int DP = 4;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, instr_valid, instr_ready, num_exc_valid;
  logic ignore_numeric_error_input, fault_request, handler_entry, int_reenable, ext_int_disable, irq, go, busy;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] num_exc_flags;
  fpe_pkg::fpe_instr_t instr, gi;
  fpe_pkg::fpe_cause_t handler_cause;
  int n_mismatch = 0;
  int total_checks = 0;
  int frc = 0;

  fpe_unit #(.STACK_DEPTH(DP)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .instr_valid, .instr, .instr_ready, .num_exc_valid, .num_exc_flags, .ignore_numeric_error_input,
    .fault_request, .handler_entry, .handler_cause, .int_reenable, .ext_int_disable, .irq
  );
  fpe_core_model core (.aclk, .aresetn, .go, .go_instr(gi), .instr_valid, .instr, .instr_ready, .busy);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Counts edges at which a fault request is seen; it must pulse once per stall.
  always @(posedge aclk)
    frc <= frc + int'(fault_request === 1'b1);

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Ready lines are held high throughout, so a response is taken at the edge it is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(nm, rd, e);
  endtask
  task automatic go_(input fpe_pkg::fpe_instr_t i);
    gi <= i;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic iss(input fpe_pkg::fpe_instr_t i);
    go_(i);
    while (busy === 1'b1)
      @(posedge aclk);
  endtask
  task automatic nw(input fpe_pkg::fpe_op_t o, input logic [5:0] f, input logic [5:0] m);
    iss('{fpe_pkg::fpe_cls_nowaitfp, o, f, m});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    chk("irq", irq, 1'h0);
    chk("ready", instr_ready, 1'h1);
    chk("int disable", ext_int_disable, 1'h0);
    rc("mask", `FPE_OFF_MASK, 32'h3f);
    rc("status", `FPE_OFF_STATUS, 32'h0);
    rc("image", `FPE_OFF_IMAGE, {8'h00, 8'h04, 8'h1c, 8'h6c});
    rc("unmapped", 8'h40, 32'h0);
    chk("rresp", rs, 2'h2);
    wr(8'h40, 32'h1);
    chk("bresp", rs, 2'h2);
    $display("test reset done");
  endtask
  task automatic t_stack;
    wr(`FPE_OFF_MASK, 32'h3e);
    wr(`FPE_OFF_IRQ_MASK, 32'h7);
    repeat (DP) nw(fpe_pkg::fpe_op_push, 6'h0, 6'h0);
    rc("full no fault", `FPE_OFF_STATUS, 32'h0);
    nw(fpe_pkg::fpe_op_push, 6'h0, 6'h0);
    rc("overflow", `FPE_OFF_STATUS, 32'hc1);
    chk("irq", irq, 1'h1);
    repeat (2) iss('{fpe_pkg::fpe_cls_int, fpe_pkg::fpe_op_none, 6'h0, 6'h0});
    rc("latched", `FPE_OFF_STATUS, 32'hc1);
    $display("test stack done");
  endtask
  task automatic t_stall;
    nw(fpe_pkg::fpe_op_none, 6'h0, 6'h0);
    chk("nowait taken", busy, 1'h0);
    go_('{fpe_pkg::fpe_cls_waitfp, fpe_pkg::fpe_op_none, 6'h0, 6'h0});
    repeat (3) @(posedge aclk);
    chk("stall ready", instr_ready, 1'h0);
    chk("stall held", busy, 1'h1);
    chk("fault pulses", frc, 32'h1);
    ignore_numeric_error_input <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("ignored", busy, 1'h0);
    ignore_numeric_error_input <= 1'b0;
    go_('{fpe_pkg::fpe_cls_wait, fpe_pkg::fpe_op_none, 6'h0, 6'h0});
    repeat (3) @(posedge aclk);
    chk("wait stall", busy, 1'h1);
    chk("fault pulses", frc, 32'h2);
    wr(`FPE_OFF_STATUS, 32'h41);
    repeat (3) @(posedge aclk);
    chk("released", busy, 1'h0);
    rc("cleared", `FPE_OFF_STATUS, 32'h0);
    $display("test stall done");
  endtask
  task automatic t_hand;
    for (int c = 0; c < 4; c++)
    begin
      handler_cause <= fpe_pkg::fpe_cause_t'(c);
      handler_entry <= 1'b1;
      @(posedge aclk);
      handler_entry <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("int disable", ext_int_disable, c != 3);
      int_reenable <= 1'b1;
      @(posedge aclk);
      int_reenable <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("reenabled", ext_int_disable, 1'h0);
    end
    $display("test handler done");
  endtask
  task automatic t_save;
    nw(fpe_pkg::fpe_op_full_restore, 6'h01, 6'h3e);
    rc("restore pend", `FPE_OFF_STATUS, 32'h81);
    nw(fpe_pkg::fpe_op_env_store, 6'h0, 6'h0);
    rc("env masks", `FPE_OFF_MASK, 32'h3f);
    rdr(`FPE_OFF_STATUS);
    chk("env flags", rd[5:0], 6'h01);
    nw(fpe_pkg::fpe_op_env_restore, 6'h01, 6'h3e);
    rc("env pend", `FPE_OFF_STATUS, 32'h81);
    nw(fpe_pkg::fpe_op_full_save, 6'h0, 6'h0);
    rc("save flags", `FPE_OFF_STATUS, 32'h0);
    rc("save masks", `FPE_OFF_MASK, 32'h3f);
    nw(fpe_pkg::fpe_op_pop, 6'h0, 6'h0);
    rc("underflow", `FPE_OFF_STATUS, 32'h41);
    wr(`FPE_OFF_STATUS, 32'h41);
    $display("test save done");
  endtask
  task automatic t_irq;
    wr(`FPE_OFF_IRQ_STAT, 32'h7);
    wr(`FPE_OFF_MASK, 32'h3b);
    num_exc_flags <= 6'h04;
    num_exc_valid <= 1'b1;
    @(posedge aclk);
    num_exc_valid <= 1'b0;
    rc("numeric pend", `FPE_OFF_STATUS, 32'h84);
    wr(`FPE_OFF_IRQ_MASK, 32'h0);
    chk("irq masked", irq, 1'h0);
    wr(`FPE_OFF_IRQ_MASK, 32'h2);
    chk("irq on", irq, 1'h1);
    wr(`FPE_OFF_IRQ_STAT, 32'h2);
    chk("irq cleared", irq, 1'h0);
    nw(fpe_pkg::fpe_op_clear, 6'h0, 6'h0);
    rc("clear op", `FPE_OFF_STATUS, 32'h0);
    $display("test irq done");
  endtask

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go, num_exc_valid} = 5'h0;
    {ignore_numeric_error_input, handler_entry, int_reenable} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    num_exc_flags = 6'h0;
    gi = '0;
    handler_cause = fpe_pkg::fpe_cause_intr;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_stack;
    t_stall;
    t_hand;
    t_save;
    t_irq;
    close_out;
  end
  initial
  begin
    repeat (3000) @(posedge aclk);
    n_mismatch++;
    close_out;
  end
endmodule

// >>> core/fpe_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
`include "fpe_regs.svh"
module fpe_axil_slave (
  input logic aclk,
  input logic aresetn,
  input logic [`FPE_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`FPE_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output fpe_pkg::fpe_wreq_t wreq,
  input logic wr_err,
  output logic [`FPE_AW-1:0] rd_addr,
  input logic [31:0] rd_data,
  input logic rd_err
);
  logic aw_full_reg, w_full_reg, wfire, aw_take, w_take, ar_take;
  logic [`FPE_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Address and data are held separately so they may arrive in either order.
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wfire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wreq = '{en: wfire, addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wfire)
        aw_full_reg <= 1'b0;
      if (w_take)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wfire)
        w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPE_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `FPE_RESP_OKAY;
    end
    else
    begin
      if (wfire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `FPE_RESP_SLVERR : `FPE_RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `FPE_RESP_SLVERR : `FPE_RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> core/fpe_stack_track.sv
// Register-stack occupancy tracker that flags pushes when full and pops when empty.
`timescale 1ns/1ps
module fpe_stack_track #(
  parameter int DEPTH = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic push,
  input logic pop,
  input logic reinit,
  output logic fault,
  output logic [$clog2(DEPTH+1)-1:0] depth_reg
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic over, under;

  // A faulting push or pop leaves the occupancy untouched so the handler can fix up the stack.
  assign over = push && (depth_reg == FULL);
  assign under = pop && (depth_reg == '0);
  assign fault = over || under;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || reinit)
      depth_reg <= '0;
    else if (push && !over)
      depth_reg <= depth_reg + CW'(1);
    else if (pop && !under)
      depth_reg <= depth_reg - CW'(1);
  end
endmodule

// >>> core/fpe_unit.sv
// Floating-point pending-exception unit with stall, delivery and register access.
// ---------------------------------------------------------------
// Function
// RULE1: A push onto a full register stack or a pop from an empty one sets the stack fault flag and the invalid flag.
// RULE2: While an unmasked exception is pending the next wait or waiting instruction is stalled and the handler invoked.
// RULE3: The stall is suppressed while the ignore-numeric-error input is high or for a no-wait instruction.
// RULE4: Delivery may come at any time up to the next waiting instruction, and software keeps handler operands until then.
// RULE5: A wait instruction forces a pending unmasked exception to be delivered before anything after it runs.
// RULE6: Entering a handler through a maskable, non-maskable or system-management interrupt disables external interrupts.
// RULE7: The no-wait full save reinitialises the unit after storing, the no-wait environment store only masks all.
// RULE8: Restoring a set flag whose mask is clear requests another exception at once.
// RULE9: Handler software clears the active flags before returning, or avoids waiting instructions while they stay.
// RULE10: The full image is 108 bytes, the environment image 28 bytes, and the status word sits at byte offset four.
// RULE11: Software gives the extended save a 512-byte area aligned on a 16-byte boundary.
// RULE12: The pending bit is latched and holds until software clears the flags behind it; the unit also drops it once those flags are masked.
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "fpe_regs.svh"
module fpe_unit #(
  parameter int STACK_DEPTH = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic [`FPE_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`FPE_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic instr_valid,
  input fpe_pkg::fpe_instr_t instr,
  output logic instr_ready,
  input logic num_exc_valid,
  input logic [`FPE_NFLAG-1:0] num_exc_flags,
  input logic ignore_numeric_error_input,
  output logic fault_request,
  input logic handler_entry,
  input fpe_pkg::fpe_cause_t handler_cause,
  input logic int_reenable,
  output logic ext_int_disable,
  output logic irq
);
  typedef enum logic {fpe_dlv_idle, fpe_dlv_hold} fpe_dlv_t;

  fpe_pkg::fpe_wreq_t wreq;
  fpe_dlv_t dlv_reg, dlv_next;
  logic [`FPE_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err, wr_err;
  logic [`FPE_NFLAG-1:0] flags_reg, flags_next, masks_reg, masks_next, flags_base, masks_base, sw_clr, hw_set;
  logic stk_flag_reg, stk_flag_next, stk_flag_base, pend_reg, pend_next, stk_fault;
  logic [`FPE_NIRQ-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_ev;
  logic accept, waiting, stall, int_dis_reg, int_dis_set;
  logic wr_status, wr_mask, wr_irq_stat, wr_irq_mask;
  logic op_save, op_env, op_restore, op_clear;
  logic [$clog2(STACK_DEPTH+1)-1:0] depth;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  fpe_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wreq(wreq),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Only the low byte lane carries the flag, mask and interrupt fields.
  assign wr_status = wreq.en && wreq.addr == `FPE_OFF_STATUS && wreq.strb[0];
  assign wr_mask = wreq.en && wreq.addr == `FPE_OFF_MASK && wreq.strb[0];
  assign wr_irq_stat = wreq.en && wreq.addr == `FPE_OFF_IRQ_STAT && wreq.strb[0];
  assign wr_irq_mask = wreq.en && wreq.addr == `FPE_OFF_IRQ_MASK && wreq.strb[0];
  assign wr_err = !(wreq.addr inside {`FPE_OFF_STATUS, `FPE_OFF_MASK, `FPE_OFF_IRQ_STAT, `FPE_OFF_IRQ_MASK,
    `FPE_OFF_IMAGE});
  assign rd_err = !(rd_addr inside {`FPE_OFF_STATUS, `FPE_OFF_MASK, `FPE_OFF_IRQ_STAT, `FPE_OFF_IRQ_MASK,
    `FPE_OFF_IMAGE});
  assign rd_data =
    (rd_addr == `FPE_OFF_STATUS) ? {23'h0, int_dis_reg, pend_reg, stk_flag_reg, flags_reg} :
    (rd_addr == `FPE_OFF_MASK) ? {26'h0, masks_reg} :
    (rd_addr == `FPE_OFF_IRQ_STAT) ? {29'h0, irq_stat_reg} :
    (rd_addr == `FPE_OFF_IRQ_MASK) ? {29'h0, irq_mask_reg} :
    (rd_addr == `FPE_OFF_IMAGE) ? {8'h0, `FPE_STATUS_POS, `FPE_ENV_IMAGE, `FPE_FULL_IMAGE} : // see RULE10
    32'h0;

  // ---------------------------------------------------------------
  // Instruction issue and stall
  // ---------------------------------------------------------------
  assign waiting = instr.cls == fpe_pkg::fpe_cls_wait || instr.cls == fpe_pkg::fpe_cls_waitfp;
  // Delivery is held back to the next waiting instruction, the latest point allowed. see RULE4
  assign stall = instr_valid && pend_reg && waiting && !ignore_numeric_error_input; // see RULE2 see RULE3 see RULE5
  assign instr_ready = !stall;
  assign accept = instr_valid && instr_ready;
  assign op_save = accept && instr.op == fpe_pkg::fpe_op_full_save;
  assign op_env = accept && instr.op == fpe_pkg::fpe_op_env_store;
  assign op_restore = accept && (instr.op == fpe_pkg::fpe_op_full_restore || instr.op == fpe_pkg::fpe_op_env_restore);
  assign op_clear = accept && instr.op == fpe_pkg::fpe_op_clear;

  fpe_stack_track #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(accept && instr.op == fpe_pkg::fpe_op_push),
    .pop(accept && instr.op == fpe_pkg::fpe_op_pop),
    .reinit(op_save),
    .fault(stk_fault),
    .depth_reg(depth)
  );

  // ---------------------------------------------------------------
  // Flags, masks and the pending bit
  // ---------------------------------------------------------------
  assign flags_base = (op_save || op_clear) ? '0 : op_restore ? instr.load_flags : flags_reg; // see RULE7 see RULE8
  assign masks_base = (op_save || op_env) ? `FPE_MASK_INIT : op_restore ? instr.load_masks :
    wr_mask ? wreq.data[`FPE_NFLAG-1:0] : masks_reg; // see RULE7
  assign stk_flag_base = (op_save || op_clear) ? 1'b0 : stk_flag_reg;
  assign sw_clr = wr_status ? wreq.data[`FPE_NFLAG-1:0] : '0;
  assign hw_set = (num_exc_valid ? num_exc_flags : '0) | (stk_fault ? `FPE_NFLAG'(1) << `FPE_FLAG_INV : '0); // see RULE1
  // A new exception in the cycle of a clear survives, since the set term is applied last.
  assign flags_next = (flags_base & ~sw_clr) | hw_set;
  assign stk_flag_next = (stk_flag_base && !(wr_status && wreq.data[`FPE_BIT_STACK_FAULT])) || stk_fault; // see RULE1
  assign masks_next = masks_base;
  // Pending follows the flags, not the instruction stream, so integer work never drops it.
  assign pend_next = |(flags_next & ~masks_next); // see RULE8 see RULE12

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_reg <= '0;
      masks_reg <= `FPE_MASK_INIT;
      stk_flag_reg <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      masks_reg <= masks_next;
      stk_flag_reg <= stk_flag_next;
      pend_reg <= pend_next;
    end
  end

  // ---------------------------------------------------------------
  // Fault delivery and interrupt recognition
  // ---------------------------------------------------------------
  always_comb
  begin
    dlv_next = dlv_reg;
    case (dlv_reg)
      fpe_dlv_idle:
        if (stall)
          dlv_next = fpe_dlv_hold;
      fpe_dlv_hold:
        if (!stall)
          dlv_next = fpe_dlv_idle;
      default:
        dlv_next = fpe_dlv_idle;
    endcase
  end

  // One request per stall episode; the core takes the handler while the instruction waits.
  assign fault_request = dlv_reg == fpe_dlv_idle && stall; // see RULE2 see RULE5
  assign int_dis_set = handler_entry && handler_cause != fpe_pkg::fpe_cause_other; // see RULE6
  assign ext_int_disable = int_dis_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dlv_reg <= fpe_dlv_idle;
      int_dis_reg <= 1'b0;
    end
    else
    begin
      dlv_reg <= dlv_next;
      int_dis_reg <= int_dis_set || (int_dis_reg && !int_reenable);
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  assign irq_ev = {fault_request, pend_next && !pend_reg, stk_fault};
  assign irq_stat_next = (irq_stat_reg & ~(wr_irq_stat ? wreq.data[`FPE_NIRQ-1:0] : '0)) | irq_ev;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_irq_mask)
        irq_mask_reg <= wreq.data[`FPE_NIRQ-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence full_push_s;
    accept && instr.op == fpe_pkg::fpe_op_push && depth == ($clog2(STACK_DEPTH+1))'(STACK_DEPTH);
  endsequence

  sequence empty_pop_s;
    accept && instr.op == fpe_pkg::fpe_op_pop && depth == '0;
  endsequence

  stack_fault_a: assert property (full_push_s or empty_pop_s // see RULE1
    |=> stk_flag_reg && flags_reg[`FPE_FLAG_INV])
    else $error("stack fault did not set the flags");
  stall_pending_a: assert property (instr_valid && waiting && pend_reg && !ignore_numeric_error_input // see RULE2
    |-> !instr_ready)
    else $error("waiting instruction passed a pending exception");
  stall_suppress_a: assert property (instr_valid && (ignore_numeric_error_input || // see RULE3
    instr.cls == fpe_pkg::fpe_cls_nowaitfp) |-> instr_ready)
    else $error("suppressed stall still blocked the instruction");
  wait_deliver_a: assert property ($rose(stall) |-> fault_request ##1 !fault_request) // see RULE5
    else $error("wait did not raise exactly one fault request");
  int_disable_a: assert property (int_dis_set |=> // see RULE6
    ext_int_disable [*2] or (ext_int_disable ##1 $past(int_reenable)))
    else $error("handler entry did not disable interrupts");
  save_reinit_a: assert property (op_save && !num_exc_valid |=> flags_reg == '0 // see RULE7
    && masks_reg == `FPE_MASK_INIT && !pend_reg && depth == '0)
    else $error("full save did not reinitialise");
  env_mask_a: assert property (op_env && !wr_status && !num_exc_valid |=> masks_reg == `FPE_MASK_INIT // see RULE7
    && flags_reg == $past(flags_reg))
    else $error("environment store changed more than the masks");
  restore_req_a: assert property (op_restore && |(instr.load_flags & ~instr.load_masks) && !wr_status // see RULE8
    |=> pend_reg ##0 (irq_stat_reg[`FPE_IRQ_PEND] || $past(pend_reg)))
    else $error("restored unmasked flag did not request an exception");
  pend_latch_a: assert property (pend_reg && !wr_status && !wr_mask && !accept |=> pend_reg) // see RULE12
    else $error("pending bit dropped without a clear");
  image_info_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `FPE_OFF_IMAGE // see RULE10
    |=> s_axi_rdata[7:0] == 8'h6c && s_axi_rdata[15:8] == 8'h1c && s_axi_rdata[23:16] == 8'h04)
    else $error("image size word is wrong");
endmodule

// >>> include/fpe_pkg.sv
// Types shared by the pending-exception unit and its register front end.
package fpe_pkg;
  typedef enum logic [1:0] {fpe_cls_int, fpe_cls_wait, fpe_cls_waitfp, fpe_cls_nowaitfp} fpe_cls_t;
  typedef enum logic [2:0] {fpe_op_none, fpe_op_push, fpe_op_pop, fpe_op_full_save, fpe_op_env_store,
    fpe_op_full_restore, fpe_op_env_restore, fpe_op_clear} fpe_op_t;
  typedef enum logic [1:0] {fpe_cause_intr, fpe_cause_nmi, fpe_cause_system_management_int,
    fpe_cause_other} fpe_cause_t;
  typedef struct packed {
    fpe_cls_t cls;
    fpe_op_t op;
    logic [5:0] load_flags;
    logic [5:0] load_masks;
  } fpe_instr_t;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } fpe_wreq_t;
endpackage

// >>> include/fpe_regs.svh
// Register offsets, field positions and reset values of the pending-exception unit.
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH
`define FPE_AW 8
`define FPE_OFF_STATUS 8'h00
`define FPE_OFF_MASK 8'h04
`define FPE_OFF_IRQ_STAT 8'h08
`define FPE_OFF_IRQ_MASK 8'h0c
`define FPE_OFF_IMAGE 8'h10
`define FPE_NFLAG 6
`define FPE_FLAG_INV 0
`define FPE_BIT_STACK_FAULT 6
`define FPE_BIT_PEND 7
`define FPE_BIT_INTDIS 8
`define FPE_MASK_INIT 6'h3f
`define FPE_NIRQ 3
`define FPE_IRQ_STACK_FAULT 0
`define FPE_IRQ_PEND 1
`define FPE_IRQ_DLV 2
`define FPE_FULL_IMAGE 8'h6c
`define FPE_ENV_IMAGE 8'h1c
`define FPE_STATUS_POS 8'h04
`define FPE_RESP_OKAY 2'h0
`define FPE_RESP_SLVERR 2'h2
`endif
